// ---- prsd_consts.svh ----
// Constants of the reference switchover and divider controller.
// Assumes inclusion by bare name from the package and the bench.
`ifndef PRSD_CONSTS_SVH
`define PRSD_CONSTS_SVH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define PRSD_CTRL_OFS 8'h00
`define PRSD_PRE_OFS 8'h04
`define PRSD_FB_OFS 8'h08
`define PRSD_POST0_OFS 8'h0C
`define PRSD_STAT_OFS 8'h20
// -----------------------------------------------------------------
// Field positions and limits
// -----------------------------------------------------------------
`define PRSD_CTRL_AUTO_BIT 0
`define PRSD_POST_HIGH_LSB 0
`define PRSD_POST_LOW_LSB 16
`define PRSD_DIV_MAX 10'h200
`define PRSD_ODD_DUTY_MAX 10'h100
`define PRSD_HALF_MAX 9'h100
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define PRSD_CTRL_RST 1'b1
`define PRSD_DIV_RST 10'h001
`define PRSD_HIGH_RST 9'h001
`define PRSD_LOW_RST 9'h001
// -----------------------------------------------------------------
// Timing counts
// -----------------------------------------------------------------
`define PRSD_LOSS_EDGES 2'h2
`endif

// ---- prsd_pkg.sv ----
// Types of the reference switchover and divider controller.
// Assumes prsd_consts.svh sits in the same folder.
`include "prsd_consts.svh"
package prsd_pkg;
  // Switchover sequence states.
  typedef enum logic [1:0] {
    PRSD_RUN,
    PRSD_GATE_WAIT,
    PRSD_SEL_WAIT
  } prsd_sw_t;

  // The whole state of the controller, registered in one process.
  typedef struct packed {
    prsd_sw_t sw;
    logic [2:0] pr_sync;
    logic [2:0] bk_sync;
    logic [2:0] req_sync;
    logic pr_q;
    logic bk_q;
    logic req_q;
    logic sel;
    logic gate;
    logic loss_pr;
    logic loss_bk;
    logic [1:0] pr_low_cnt;
    logic [1:0] bk_low_cnt;
    logic mux_ref;
    logic auto_en;
    logic [9:0] pre_div;
    logic [9:0] fb_div;
    logic [9:0] pre_cnt;
    logic [9:0] fb_cnt;
    logic pump_up;
    logic pump_dn;
    logic cas_loaded;
    logic [4:0] cascade;
    logic [4:0][8:0] c_high;
    logic [4:0][8:0] c_low;
    logic [4:0][8:0] c_cnt;
    logic [4:0] c_out;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } prsd_state_t;
endpackage : prsd_pkg

// ---- prsd_core.sv ----
// Reference clock switchover, pre-scale, feedback and five post-scale dividers.
// Assumes one 40 MHz clk standing in for the oscillator; reference pins are
// asynchronous and pass three flip-flops; registers sit on AXI4-Lite.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module prsd_core
  import prsd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic primary_ref_in,
  input wire logic backup_ref_in,
  input wire logic swap_req,
  input wire logic pfd_enable,
  input wire logic [4:0] cascade_cfg,
  output logic ref_mux_out,
  output logic pump_up,
  output logic pump_dn,
  output logic [4:0] post_clk_out,
  output logic primary_lost,
  output logic backup_lost,
  output logic active_backup,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic s_axi_rvalid,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic s_axi_rready
);

  // -----------------------------------------------------------------
  // State registers
  // -----------------------------------------------------------------
  prsd_state_t st_reg; // Present state of the whole controller.
  prsd_state_t st_next; // Next state computed each cycle.

  // Response codes of the register bus.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // -----------------------------------------------------------------
  // Register image and legality helpers
  // -----------------------------------------------------------------

  // Returns the word that a read of the given offset shows.
  function automatic logic [31:0] read_word(input prsd_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == `PRSD_CTRL_OFS) begin
      w[`PRSD_CTRL_AUTO_BIT] = s.auto_en;
    end else if (a == `PRSD_PRE_OFS) begin
      w[9:0] = s.pre_div;
    end else if (a == `PRSD_FB_OFS) begin
      w[9:0] = s.fb_div;
    end else if (a == `PRSD_STAT_OFS) begin
      // Status shows the switchover engine and the latched cascade layout.
      w[0] = s.loss_pr;
      w[1] = s.loss_bk;
      w[2] = s.sel;
      w[3] = s.gate;
      w[5:4] = s.sw;
      w[12:8] = s.cascade;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (a == 8'(`PRSD_POST0_OFS + 4 * i)) begin
          w[`PRSD_POST_HIGH_LSB +: 9] = s.c_high[i];
          w[`PRSD_POST_LOW_LSB +: 9] = s.c_low[i];
        end
      end
    end
    return w;
  endfunction : read_word

  // True when the offset names a register at all.
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == `PRSD_CTRL_OFS) || (a == `PRSD_PRE_OFS) || (a == `PRSD_FB_OFS)
      || (a == `PRSD_STAT_OFS);
    for (int i = 0; i < 5; i++) begin
      if (a == 8'(`PRSD_POST0_OFS + 4 * i)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_mapped

  // A divide setting for pre-scale or feedback must lie in 1..512.
  function automatic logic div_ok(input logic [9:0] d);
    return (d != 10'h000) && (d <= `PRSD_DIV_MAX);
  endfunction : div_ok

  // A post-scale pair is legal when its sum fits the duty-cycle range.
  // Low count zero with high count one is the divide-by-one bypass.
  function automatic logic post_ok(input logic [8:0] h, input logic [8:0] l);
    logic [9:0] sum;
    sum = {1'b0, h} + {1'b0, l};
    if (h == 9'h000 || h > `PRSD_HALF_MAX || l > `PRSD_HALF_MAX) begin
      return 1'b0;
    end
    if (l == 9'h000) begin
      return h == 9'h001;
    end
    // An uneven split only reaches 256; an even split reaches 512.
    return (h == l) ? (sum <= `PRSD_DIV_MAX) : (sum <= `PRSD_ODD_DUTY_MAX);
  endfunction : post_ok

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------

  // One process computes the whole next state from the present one.
  always_comb begin
    logic pr_n, bk_n, req_n;
    logic pr_fall, bk_fall, pr_rise, bk_rise, req_rise;
    logic old_fall, new_fall, cur_lost, oth_lost, mux_fall;
    logic ref_ev, fb_ev, up_n, dn_n;
    logic prev_rise, tick;
    logic [31:0] img, mask, merged;
    logic [7:0] wa;
    pr_n = 1'b0;
    bk_n = 1'b0;
    req_n = 1'b0;
    pr_fall = 1'b0;
    bk_fall = 1'b0;
    pr_rise = 1'b0;
    bk_rise = 1'b0;
    req_rise = 1'b0;
    old_fall = 1'b0;
    new_fall = 1'b0;
    cur_lost = 1'b0;
    oth_lost = 1'b0;
    mux_fall = 1'b0;
    ref_ev = 1'b0;
    fb_ev = 1'b0;
    up_n = 1'b0;
    dn_n = 1'b0;
    prev_rise = 1'b0;
    tick = 1'b0;
    img = 32'h0000_0000;
    mask = 32'h0000_0000;
    merged = 32'h0000_0000;
    wa = 8'h00;
    st_next = st_reg;

    // Pin inputs shift through three stages; a level counts once the last
    // two stages agree, so a single metastable sample never reaches logic.
    st_next.pr_sync = {st_reg.pr_sync[1:0], primary_ref_in};
    st_next.bk_sync = {st_reg.bk_sync[1:0], backup_ref_in};
    st_next.req_sync = {st_reg.req_sync[1:0], swap_req};
    pr_n = (st_reg.pr_sync[2] == st_reg.pr_sync[1]) ? st_reg.pr_sync[2] : st_reg.pr_q;
    bk_n = (st_reg.bk_sync[2] == st_reg.bk_sync[1]) ? st_reg.bk_sync[2] : st_reg.bk_q;
    req_n = (st_reg.req_sync[2] == st_reg.req_sync[1]) ? st_reg.req_sync[2] : st_reg.req_q;
    st_next.pr_q = pr_n;
    st_next.bk_q = bk_n;
    st_next.req_q = req_n;
    pr_fall = st_reg.pr_q & ~pr_n;
    bk_fall = st_reg.bk_q & ~bk_n;
    pr_rise = ~st_reg.pr_q & pr_n;
    bk_rise = ~st_reg.bk_q & bk_n;
    // Only the rising edge of the request matters, never its level.
    req_rise = ~st_reg.req_q & req_n;

    // Clock sense: an input is lost once the other input has fallen twice
    // while it stayed low. The other input is the time base, which is why
    // the detection only holds for inputs close in frequency.
    if (pr_rise) begin
      st_next.pr_low_cnt = 2'h0;
      st_next.loss_pr = 1'b0;
    end else if (bk_fall && !pr_n && !st_reg.loss_pr) begin
      st_next.pr_low_cnt = st_reg.pr_low_cnt + 2'h1;
      st_next.loss_pr = (st_reg.pr_low_cnt + 2'h1) == `PRSD_LOSS_EDGES;
    end
    if (bk_rise) begin
      st_next.bk_low_cnt = 2'h0;
      st_next.loss_bk = 1'b0;
    end else if (pr_fall && !bk_n && !st_reg.loss_bk) begin
      st_next.bk_low_cnt = st_reg.bk_low_cnt + 2'h1;
      st_next.loss_bk = (st_reg.bk_low_cnt + 2'h1) == `PRSD_LOSS_EDGES;
    end

    // Old input is the one feeding the loop now; new one is the other.
    old_fall = st_reg.sel ? bk_fall : pr_fall;
    new_fall = st_reg.sel ? pr_fall : bk_fall;
    cur_lost = st_reg.sel ? st_reg.loss_bk : st_reg.loss_pr;
    oth_lost = st_reg.sel ? st_reg.loss_pr : st_reg.loss_bk;

    // Switchover sequence.
    case (st_reg.sw)
      PRSD_RUN: begin
        if (req_rise) begin
          // A manual request wins over automatic sensing.
          if (cur_lost) begin
            st_next.gate = 1'b0;
            st_next.sw = PRSD_SEL_WAIT;
          end else begin
            st_next.sw = PRSD_GATE_WAIT;
          end
        end else if (st_reg.auto_en && cur_lost && !oth_lost) begin
          // The dead input gives no falling edge, so gate at once; it is
          // already low, which keeps the counter reference quiet.
          st_next.gate = 1'b0;
          st_next.sw = PRSD_SEL_WAIT;
        end
      end
      PRSD_GATE_WAIT: begin
        if (old_fall || cur_lost) begin
          st_next.gate = 1'b0;
          st_next.sw = PRSD_SEL_WAIT;
        end
      end
      PRSD_SEL_WAIT: begin
        // Stays here for as long as the target input is not toggling.
        if (new_fall) begin
          st_next.sel = ~st_reg.sel;
          st_next.gate = 1'b1;
          st_next.sw = PRSD_RUN;
        end
      end
      default: begin
        st_next.sw = PRSD_RUN;
      end
    endcase

    // Gated reference mux. Reopening happens when the new input has just
    // fallen, so the first level passed through is low and no runt appears.
    st_next.mux_ref = st_next.gate & (st_next.sel ? bk_n : pr_n);
    mux_fall = st_reg.mux_ref & ~st_next.mux_ref;

    // Pre-scale counter counts reference periods; it has no duty control.
    if (mux_fall) begin
      if (st_reg.pre_cnt >= st_reg.pre_div - 10'h001) begin
        st_next.pre_cnt = 10'h000;
        ref_ev = 1'b1;
      end else begin
        st_next.pre_cnt = st_reg.pre_cnt + 10'h001;
      end
    end
    // Feedback counter divides the oscillator stand-in clock.
    if (st_reg.fb_cnt >= st_reg.fb_div - 10'h001) begin
      st_next.fb_cnt = 10'h000;
      fb_ev = 1'b1;
    end else begin
      st_next.fb_cnt = st_reg.fb_cnt + 10'h001;
    end

    // Phase-frequency detector: reference sets up, feedback sets down, both
    // together reset. Disabled, both pumps rest low and the loop holds.
    up_n = st_reg.pump_up | ref_ev;
    dn_n = st_reg.pump_dn | fb_ev;
    if (!pfd_enable || (up_n && dn_n)) begin
      st_next.pump_up = 1'b0;
      st_next.pump_dn = 1'b0;
    end else begin
      st_next.pump_up = up_n;
      st_next.pump_dn = dn_n;
    end

    // Cascade layout is caught once after reset and never rewritten.
    if (!st_reg.cas_loaded) begin
      st_next.cascade = cascade_cfg;
      st_next.cas_loaded = 1'b1;
    end

    // Post-scale counters. A cascaded counter ticks on the rising edge of
    // the previous output, so the chain divides by the product.
    for (int i = 0; i < 5; i++) begin
      tick = (i == 0) || !st_reg.cascade[i] || prev_rise;
      if (tick && st_reg.cas_loaded) begin
        if (st_reg.c_low[i] == 9'h000) begin
          // Bypass: follow the source as fast as a flop can.
          st_next.c_out[i] = ~st_reg.c_out[i];
        end else if (st_reg.c_cnt[i] <= 9'h001) begin
          // Phase ends; load the other phase length.
          st_next.c_out[i] = ~st_reg.c_out[i];
          st_next.c_cnt[i] = st_reg.c_out[i] ? st_reg.c_low[i] : st_reg.c_high[i];
        end else begin
          st_next.c_cnt[i] = st_reg.c_cnt[i] - 9'h001;
        end
      end
      prev_rise = ~st_reg.c_out[i] & st_next.c_out[i];
    end

    // -----------------------------------------------------------------
    // AXI4-Lite write channel
    // -----------------------------------------------------------------
    if (st_reg.awready && s_axi_awvalid) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (st_reg.wready && s_axi_wvalid) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Perform the write once both halves are held and no answer waits.
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      wa = {st_reg.aw_addr[7:2], 2'b00};
      img = read_word(st_reg, wa);
      for (int b = 0; b < 4; b++) begin
        mask[8 * b +: 8] = {8{st_reg.w_strb[b]}};
      end
      merged = (img & ~mask) | (st_reg.w_data & mask);
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (!is_mapped(wa)) begin
        st_next.bresp = RESP_DECERR;
      end else if (wa == `PRSD_CTRL_OFS) begin
        st_next.auto_en = merged[`PRSD_CTRL_AUTO_BIT];
      end else if (wa == `PRSD_PRE_OFS || wa == `PRSD_FB_OFS) begin
        // Illegal divides are refused whole, keeping the old setting.
        if (!div_ok(merged[9:0])) begin
          st_next.bresp = RESP_SLVERR;
        end else if (wa == `PRSD_PRE_OFS) begin
          st_next.pre_div = merged[9:0];
        end else begin
          st_next.fb_div = merged[9:0];
        end
      end else if (wa == `PRSD_STAT_OFS) begin
        st_next.bresp = RESP_SLVERR;
      end else begin
        for (int i = 0; i < 5; i++) begin
          if (wa == 8'(`PRSD_POST0_OFS + 4 * i)) begin
            if (post_ok(merged[`PRSD_POST_HIGH_LSB +: 9], merged[`PRSD_POST_LOW_LSB +: 9])) begin
              st_next.c_high[i] = merged[`PRSD_POST_HIGH_LSB +: 9];
              st_next.c_low[i] = merged[`PRSD_POST_LOW_LSB +: 9];
            end else begin
              st_next.bresp = RESP_SLVERR;
            end
          end
        end
      end
    end
    st_next.awready = !st_next.aw_have;
    st_next.wready = !st_next.w_have;

    // -----------------------------------------------------------------
    // AXI4-Lite read channel
    // -----------------------------------------------------------------
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.arready && s_axi_arvalid) begin
      wa = {s_axi_araddr[7:2], 2'b00};
      st_next.rvalid = 1'b1;
      st_next.rdata = read_word(st_reg, wa);
      st_next.rresp = is_mapped(wa) ? RESP_OKAY : RESP_DECERR;
    end
    st_next.arready = !st_next.rvalid;
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------

  // Synchronous reset puts the loop on the primary input with clean flags.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.sw <= PRSD_RUN;
      st_reg.sel <= 1'b0;
      st_reg.gate <= 1'b1;
      st_reg.loss_pr <= 1'b0;
      st_reg.loss_bk <= 1'b0;
      st_reg.auto_en <= `PRSD_CTRL_RST;
      st_reg.pre_div <= `PRSD_DIV_RST;
      st_reg.fb_div <= `PRSD_DIV_RST;
      st_reg.c_high <= {5{`PRSD_HIGH_RST}};
      st_reg.c_low <= {5{`PRSD_LOW_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  // -----------------------------------------------------------------
  // Outputs, each straight from a state flip-flop
  // -----------------------------------------------------------------
  assign ref_mux_out = st_reg.mux_ref;
  assign pump_up = st_reg.pump_up;
  assign pump_dn = st_reg.pump_dn;
  assign post_clk_out = st_reg.c_out;
  assign primary_lost = st_reg.loss_pr;
  assign backup_lost = st_reg.loss_bk;
  assign active_backup = st_reg.sel;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
endmodule : prsd_core
`default_nettype wire

// ---- prsd_properties.sv ----
// Port checker for the reference switchover controller.
// Assumes it is bound to prsd_core, one clock clk and reset rst.
`timescale 1ns/10ps
`default_nettype none
module prsd_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic primary_ref_in,
  input wire logic backup_ref_in,
  input wire logic swap_req,
  input wire logic pfd_enable,
  input wire logic pump_up,
  input wire logic pump_dn,
  input wire logic primary_lost,
  input wire logic backup_lost,
  input wire logic active_backup,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // Leaving reset shows the primary selected and nothing lost.
  reset_state_a: assert property ($fell(rst) |->
    !active_backup && !primary_lost && !backup_lost) else $error("Bad state after reset.");
  // The primary loss flag rises only after its pin sat low for a while.
  loss_low_a: assert property ($rose(primary_lost) |->
    !$past(primary_ref_in, 3) && !$past(primary_ref_in, 8)) else $error("Early loss flag.");
  // A pin that stays high cannot be flagged as lost.
  pr_clear_a: assert property (primary_ref_in [*6] |-> !primary_lost)
    else $error("Primary flagged while running.");
  bk_clear_a: assert property (backup_ref_in [*6] |-> !backup_lost)
    else $error("Backup flagged while running.");
  // Selection moves only while the new input is low, so no glitch.
  mux_fall_a: assert property ($changed(active_backup) |->
    (active_backup ? !$past(backup_ref_in) : !$past(primary_ref_in)))
    else $error("Selection moved off a falling edge.");
  // Dropping the request leaves the selection unchanged for the next eight cycles.
  swap_fall_a: assert property ($fell(swap_req) |=> $stable(active_backup) [*8])
    else $error("Request fall changed selection.");
  // Losing the active primary moves to the backup in bounded time.
  auto_swap_a: assert property ($rose(primary_lost) && !active_backup |->
    ##[1:60] active_backup) else $error("No automatic swap.");
  // With the detector off the pump outputs stand still.
  pump_hold_a: assert property (!pfd_enable [*3] |->
    $stable(pump_up) && $stable(pump_dn)) else $error("Pump moved while disabled.");
  // A write answer stands until it is taken.
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write answer dropped.");
  cover property ($rose(primary_lost));
  cover property ($changed(active_backup) && !swap_req);
  cover property ($rose(swap_req) ##[1:60] $changed(active_backup));
endmodule : prsd_properties
bind prsd_core prsd_properties u_prsd_properties (.*);
`default_nettype wire

// ---- prsd_ref_model.sv ----
// Behavioural model of the two reference sources.
// Assumes the bench clock clk; a stopped source parks its pin low.
`timescale 1ns/10ps
`default_nettype none
module prsd_ref_model #(
  parameter int HALF_PR = 6,
  parameter int HALF_BK = 7
) (
  input wire logic clk,
  input wire logic run_pr,
  input wire logic run_bk,
  output logic primary_ref_in,
  output logic backup_ref_in
);
  // Periods of 12 and 14 ticks keep the two sources within a fifth.
  int cp = 0;
  int cb = 2;
  initial primary_ref_in = 1'b0;
  initial backup_ref_in = 1'b0;
  // Each source toggles every half period; a stopped one falls and stays low.
  always @(posedge clk) begin
    cp <= (cp + 1) % HALF_PR;
    cb <= (cb + 1) % HALF_BK;
    if (cp == HALF_PR - 1) primary_ref_in <= run_pr & ~primary_ref_in;
    if (cb == HALF_BK - 1) backup_ref_in <= run_bk & ~backup_ref_in;
  end
endmodule : prsd_ref_model
`default_nettype wire

// ---- prsd_bench.sv ----
// Self-checking bench for the switchover and divider controller.
// Assumes prsd_core, prsd_ref_model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
`include "prsd_consts.svh"
module prsd_bench;
  import prsd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, swap_req = 1'b0, pfd_enable = 1'b1, run_pr = 1'b1;
  logic run_bk = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, primary_ref_in, backup_ref_in, ref_mux_out, pump_up, pump_dn;
  logic primary_lost, backup_lost, active_backup, awready, wready, bvalid, arready, rvalid;
  logic [4:0] post_clk_out;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] flags;
  int errors = 0, comparisons = 0, mux_hi = 0;
  assign flags = {active_backup, backup_lost, primary_lost};
  // ---------------------------------------------------------------
  // Device and reference sources
  // ---------------------------------------------------------------
  prsd_ref_model u_prsd_ref_model (.clk(clk), .run_pr(run_pr), .run_bk(run_bk),
    .primary_ref_in(primary_ref_in), .backup_ref_in(backup_ref_in));
  // The cascade setting is read once, so it stays tied: counter 1 follows 0.
  prsd_core u_prsd_core (.clk(clk), .rst(rst), .primary_ref_in(primary_ref_in),
    .backup_ref_in(backup_ref_in), .swap_req(swap_req), .pfd_enable(pfd_enable),
    .cascade_cfg(5'h02), .ref_mux_out(ref_mux_out), .pump_up(pump_up), .pump_dn(pump_dn),
    .post_clk_out(post_clk_out), .primary_lost(primary_lost), .backup_lost(backup_lost),
    .active_backup(active_backup), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  always #12.5 clk = ~clk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("Counts: %0d comparisons, %0d errors.", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Write one word and compare the response code.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk("bvalid", bvalid, 1'b1);
    chk("bresp", bresp, er);
  endtask : axw
  // Read one word; rready stands until the answer is seen or 50 ticks pass.
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    chk("rvalid", rvalid, 1'b1);
    chk("rresp", rresp, er);
    if (er == 2'b00) chk("rdata", rd, ed);
  endtask : axr
  // Wait a bounded time for a status bit, then compare it.
  task automatic wait_bit(input int i, input logic v);
    int n;
    n = 0;
    while (flags[i] !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("status", flags[i], v);
  endtask : wait_bit
  // Count high and low ticks of one post-scale output.
  task automatic meas(input int i, input int hi, input int lo);
    int h, l;
    h = 0;
    l = 0;
    @(posedge clk iff post_clk_out[i] === 1'b0);
    @(posedge clk iff post_clk_out[i] === 1'b1);
    while (post_clk_out[i] === 1'b1 && h < 2000) begin
      @(posedge clk);
      h++;
    end
    while (post_clk_out[i] === 1'b0 && l < 2000) begin
      @(posedge clk);
      l++;
    end
    chk("post high", h, hi);
    chk("post low", l, lo);
  endtask : meas
  // Raise the request long enough, then drop it and let things settle.
  task automatic swap(input logic ev);
    @(posedge clk);
    swap_req <= 1'b1;
    repeat (48) @(posedge clk);
    chk("active", active_backup, ev);
    chk("losses", {primary_lost, backup_lost}, 2'b00);
    swap_req <= 1'b0;
    repeat (48) @(posedge clk);
    chk("active", active_backup, ev);
  endtask : swap
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset flags", flags, 3'b000);
    axr(`PRSD_CTRL_OFS, 32'h1, 2'b00);
    axr(`PRSD_PRE_OFS, 32'h1, 2'b00);
    axr(`PRSD_STAT_OFS, 32'h0000_0208, 2'b00);
    axr(8'h40, 32'h0, 2'b11);
    axw(`PRSD_STAT_OFS, 32'h0, 2'b10);
    $display("Test reset and map done.");
    axw(`PRSD_PRE_OFS, 32'h200, 2'b00);
    axw(`PRSD_PRE_OFS, 32'h0, 2'b10);
    axr(`PRSD_PRE_OFS, 32'h200, 2'b00);
    axw(`PRSD_FB_OFS, 32'h201, 2'b10);
    axw(`PRSD_POST0_OFS + 8'h08, 32'h0064_00C8, 2'b10);
    axw(`PRSD_POST0_OFS + 8'h08, 32'h0100_0100, 2'b00);
    axr(`PRSD_POST0_OFS + 8'h08, 32'h0100_0100, 2'b00);
    $display("Test divide limits done.");
    meas(0, 1, 1);
    axw(`PRSD_POST0_OFS, 32'h0005_0003, 2'b00);
    meas(0, 3, 5);
    meas(1, 8, 8);
    meas(2, 256, 256);
    meas(4, 1, 1);
    // The primary is a square wave of 12 ticks, so any 24 ticks hold 12 high.
    repeat (24) begin
      @(posedge clk);
      mux_hi += ref_mux_out;
    end
    chk("mux high", mux_hi, 32'h0000_000C);
    $display("Test post-scale done.");
    swap(1'b1);
    swap(1'b0);
    $display("Test manual swap done.");
    pfd_enable <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pumps off", {pump_up, pump_dn}, 2'b00);
    pfd_enable <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pump down", pump_dn, 1'b1);
    run_pr <= 1'b0;
    wait_bit(0, 1'b1);
    wait_bit(2, 1'b1);
    run_pr <= 1'b1;
    wait_bit(0, 1'b0);
    run_bk <= 1'b0;
    wait_bit(1, 1'b1);
    wait_bit(2, 1'b0);
    run_bk <= 1'b1;
    wait_bit(1, 1'b0);
    $display("Test automatic swap done.");
    test_done();
  end
  // The whole sequence needs under two thousand ticks; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : prsd_bench
`default_nettype wire
